// ---- design/fmr_pkg.sv ----
// Shared constants for the field-network master link reliability block.
package fmr_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SBNO = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_ERRINV = 8'h0C;
	localparam logic [7:0] OFS_RYOUT = 8'h10;
	localparam logic [7:0] OFS_RWWOUT = 8'h14;
	localparam logic [7:0] OFS_RXIN = 8'h18;
	localparam logic [7:0] OFS_RWRIN = 8'h20;
	// Control field positions.
	localparam int CB_START = 0;
	localparam int CB_TYPE_SB = 1;
	localparam int CB_FCLR = 2;
	localparam int CB_STOPCLR = 3;
	localparam int CB_YDEV = 4;
	localparam int CB_CONT = 5;
	localparam int CB_SBCFG = 6;
	localparam int CB_DUPLEX = 7;
	localparam int CB_RECON_LO = 8;
	localparam int CB_RECON_HI = 11;
	// Status field positions.
	localparam int SB_STATE_LO = 0;
	localparam int SB_STNO_LO = 8;
	localparam int SB_CYC = 16;
	localparam int SB_STOP = 17;
	localparam int SB_DOWN = 18;
	localparam int SB_CUT_LO = 24;
	// Reset values.
	localparam logic [31:0] RST_CTRL = 32'h0000_0100;
	localparam logic [6:0] RST_SBNO = 7'h01;
	// Station number taken by whichever station controls the link.
	localparam logic [6:0] CTL_STNO = 7'h00;
	// Bus responses.
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Link role states.
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CTRL = 4'h2,
		ST_STBY = 4'h4,
		ST_OFF = 4'h8
	} fmr_state_e;
endpackage

// ---- design/fmr_link_ctl.sv ----
// Link reliability control: cut-off, return, stop handling and master duplexing.
// Operation
// - Faulty slaves are cut off; exchange continues with healthy stations.
// - Cut-off stations reconnect when healthy, limited by reconnection count.
// - Host operation-stopping error with continue selected keeps cyclic exchange.
// - Configured standby master overrides continue; control is handed over.
// - Faulty-station input bits are cleared or held per setting.
// - Faulty-station read registers are always held.
// - Error-invalid stations keep their input bits held regardless.
// - Output-area refresh device: outputs cleared whenever host CPU stops.
// - Other refresh device: outputs kept or cleared per stop-clear setting.
// - Inputs and register areas keep refreshing during host CPU stop.
// - Stop-clear refuses tool forced output while host CPU stopped.
// - Stop-clear also applies to direct buffer writes of output bits.
// - Master system down switches link control to the standby master.
// - Recovered former master rejoins as standby while standby controls.
// - Standby taking control changes its station number to zero.
// - Rejoining master takes the configured standby station number.
// - Controlling standby sends host-written outputs to other stations.
// - Controlling standby clears or holds faulty-station input per setting.
`timescale 1ns/10ps
`default_nettype none
module fmr_link_ctl #(
	parameter int NSTN = 4,
	parameter int BW = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic host_stop,
	input wire logic host_err,
	input wire logic host_down,
	input wire logic ctl_fail,
	input wire logic cyc_strobe,
	input wire logic [NSTN-1:0] stn_ok,
	input wire logic [NSTN*BW-1:0] rx_in,
	input wire logic [NSTN*16-1:0] rwr_in,
	input wire logic force_req,
	input wire logic [NSTN*BW-1:0] force_data,
	output logic force_refused,
	output logic link_ctl,
	output logic cyc_active,
	output logic [6:0] stn_no,
	output logic [NSTN-1:0] cut_mask,
	output logic [NSTN*BW-1:0] remote_output_bits,
	output logic [31:0] remote_write_registers
);
	////////////////////////////////////////////////////////////////////////////
	// Host status pins come from another domain, so each passes two flops.
	logic [2:0] hs1_r, hs2_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hs1_r <= 3'h0;
			hs2_r <= 3'h0;
		end else begin
			hs1_r <= {host_down, host_err, host_stop};
			hs2_r <= hs1_r;
		end
	end
	wire cpu_stop = hs2_r[0] | hs2_r[1];
	wire cpu_err = hs2_r[1];
	wire sys_down = hs2_r[2];

	////////////////////////////////////////////////////////////////////////////
	// Register file.
	logic [31:0] ctrl_r, ry_r, rww_r;
	logic [6:0] sbno_r;
	logic [NSTN-1:0] errinv_r;
	logic [NSTN*BW-1:0] rx_r;
	logic [15:0] rwr_r [NSTN];
	logic [NSTN-1:0] cut_r;
	fmr_pkg::fmr_state_e state_r, state_nxt;
	logic [6:0] stn_r, stn_nxt;

	wire c_start = ctrl_r[fmr_pkg::CB_START];
	wire c_type_sb = ctrl_r[fmr_pkg::CB_TYPE_SB];
	wire c_fclr = ctrl_r[fmr_pkg::CB_FCLR];
	wire c_stopclr = ctrl_r[fmr_pkg::CB_STOPCLR];
	wire c_ydev = ctrl_r[fmr_pkg::CB_YDEV];
	wire c_cont = ctrl_r[fmr_pkg::CB_CONT];
	wire c_sbcfg = ctrl_r[fmr_pkg::CB_SBCFG];
	wire c_duplex = ctrl_r[fmr_pkg::CB_DUPLEX];
	wire [3:0] c_recon = ctrl_r[fmr_pkg::CB_RECON_HI:fmr_pkg::CB_RECON_LO];

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel; address and data may arrive in either order.
	logic aw_full_r, w_full_r, bvalid_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r;

	assign s_axi_awready = !aw_full_r && !bvalid_r;
	assign s_axi_wready = !w_full_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	wire wr_go = aw_full_r && w_full_r && !bvalid_r;
	wire wr_ctrl = wr_go && awaddr_r == fmr_pkg::OFS_CTRL;
	wire wr_sbno = wr_go && awaddr_r == fmr_pkg::OFS_SBNO;
	wire wr_einv = wr_go && awaddr_r == fmr_pkg::OFS_ERRINV;
	wire wr_ry = wr_go && awaddr_r == fmr_pkg::OFS_RYOUT;
	wire wr_rww = wr_go && awaddr_r == fmr_pkg::OFS_RWWOUT;
	wire wr_ok = wr_ctrl | wr_sbno | wr_einv | wr_ry | wr_rww;

	// Byte-lane merge used by the control, output-bit and write-register registers.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				m[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return m;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			bvalid_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bresp_r <= fmr_pkg::RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? fmr_pkg::RESP_OK : fmr_pkg::RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Forced output from the tool is refused while stopped with stop-clear.
	wire force_block = cpu_stop && c_stopclr;
	wire force_take = force_req && !force_block && !wr_ry;

	// Software registers. A bus write to the output bits wins over a force
	// in the same cycle, which is then dropped rather than queued.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= fmr_pkg::RST_CTRL;
			sbno_r <= fmr_pkg::RST_SBNO;
			errinv_r <= '0;
			ry_r <= 32'h0000_0000;
			rww_r <= 32'h0000_0000;
			force_refused <= 1'b0;
		end else begin
			force_refused <= force_req && force_block;
			if (wr_ctrl) begin
				ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
			end
			if (wr_sbno && wstrb_r[0]) begin
				sbno_r <= wdata_r[6:0];
			end
			if (wr_einv && wstrb_r[0]) begin
				errinv_r <= wdata_r[NSTN-1:0];
			end
			if (wr_ry) begin
				ry_r <= merge(ry_r, wdata_r, wstrb_r);
			end else if (force_take) begin
				ry_r <= 32'(force_data);
			end
			if (wr_rww) begin
				rww_r <= merge(rww_r, wdata_r, wstrb_r);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel: one read at a time, answer one cycle after ARVALID.
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
	wire [5:0] ra_idx = ra[7:2] - fmr_pkg::OFS_RWRIN[7:2];
	wire ra_rwr = ra >= fmr_pkg::OFS_RWRIN && ra_idx < 6'(NSTN);
	wire [31:0] stat_w = {(8 - NSTN)'(0), cut_r, 5'h00, sys_down, cpu_stop, link_ctl,
		1'b0, stn_r, 4'h0, state_r};
	logic [31:0] rd_mux;
	logic rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (ra)
			fmr_pkg::OFS_CTRL: rd_mux = ctrl_r;
			fmr_pkg::OFS_SBNO: rd_mux = {25'h0, sbno_r};
			fmr_pkg::OFS_STAT: rd_mux = stat_w;
			fmr_pkg::OFS_ERRINV: rd_mux = 32'(errinv_r);
			fmr_pkg::OFS_RYOUT: rd_mux = ry_r;
			fmr_pkg::OFS_RWWOUT: rd_mux = rww_r;
			fmr_pkg::OFS_RXIN: rd_mux = 32'(rx_r);
			default: begin
				rd_hit = ra_rwr;
				rd_mux = ra_rwr ? {16'h0, rwr_r[ra_idx[$clog2(NSTN)-1:0]]} : 32'h0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= fmr_pkg::RESP_OK;
		end else if (s_axi_arvalid && !rvalid_r) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= rd_hit ? fmr_pkg::RESP_OK : fmr_pkg::RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link role. A host error hands control to a configured standby
	// even with continue selected; without a standby, continue keeps the link; system down always drops it.
	wire lose_ctl = sys_down || (cpu_err && (c_sbcfg || !c_cont));
	always_comb begin
		state_nxt = state_r;
		stn_nxt = stn_r;
		case (state_r)
			fmr_pkg::ST_IDLE: begin
				if (c_start) begin
					state_nxt = c_type_sb ? fmr_pkg::ST_STBY : fmr_pkg::ST_CTRL;
					stn_nxt = c_type_sb ? sbno_r : fmr_pkg::CTL_STNO;
				end
			end
			fmr_pkg::ST_CTRL: begin
				if (lose_ctl) begin
					state_nxt = fmr_pkg::ST_OFF;
				end
			end
			fmr_pkg::ST_STBY: begin
				if (ctl_fail && !sys_down && !cpu_err) begin
					state_nxt = fmr_pkg::ST_CTRL;
					stn_nxt = fmr_pkg::CTL_STNO;
				end else if (sys_down) begin
					state_nxt = fmr_pkg::ST_OFF;
				end
			end
			fmr_pkg::ST_OFF: begin
				if (!sys_down && !cpu_err && c_duplex) begin
					state_nxt = fmr_pkg::ST_STBY;
					stn_nxt = sbno_r;
				end
			end
			default: begin
				state_nxt = fmr_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= fmr_pkg::ST_IDLE;
			stn_r <= fmr_pkg::CTL_STNO;
		end else begin
			state_r <= state_nxt;
			stn_r <= stn_nxt;
		end
	end
	assign link_ctl = state_r == fmr_pkg::ST_CTRL;
	assign cyc_active = link_ctl || state_r == fmr_pkg::ST_STBY;
	assign stn_no = stn_r;

	////////////////////////////////////////////////////////////////////////////
	// Cut-off and return. Faulty stations drop out at once; recovered ones
	// return lowest first, at most c_recon per cycle so a flapping segment
	// cannot flood one link scan with reconnections.
	logic [NSTN-1:0] cut_nxt;
	logic [4:0] recon_used;
	always_comb begin
		cut_nxt = cut_r;
		recon_used = 5'h00;
		for (int i = 0; i < NSTN; i++) begin
			if (!stn_ok[i]) begin
				cut_nxt[i] = 1'b1;
			end else if (cut_r[i] && recon_used < {1'b0, c_recon}) begin
				cut_nxt[i] = 1'b0;
				recon_used = recon_used + 5'h01;
			end
		end
	end

	// Receive areas refresh on every cycle strobe, host stop or not.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cut_r <= '0;
			rx_r <= '0;
			for (int i = 0; i < NSTN; i++) begin
				rwr_r[i] <= 16'h0000;
			end
		end else if (cyc_strobe) begin
			cut_r <= cut_nxt;
			for (int i = 0; i < NSTN; i++) begin
				if (!cut_nxt[i]) begin
					rx_r[i*BW +: BW] <= rx_in[i*BW +: BW];
					rwr_r[i] <= rwr_in[i*16 +: 16];
				end else if (c_fclr && !errinv_r[i]) begin
					rx_r[i*BW +: BW] <= '0;
				end
			end
		end
	end
	assign cut_mask = cut_r;

	////////////////////////////////////////////////////////////////////////////
	// Send areas. Whichever station controls the link sends what the host
	// wrote; the stop-clear also covers direct buffer writes.
	wire ry_clear = cpu_stop && (c_ydev || c_stopclr);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remote_output_bits <= '0;
			remote_write_registers <= 32'h0000_0000;
		end else begin
			remote_output_bits <= ry_clear ? '0 : ry_r[NSTN*BW-1:0];
			remote_write_registers <= rww_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	AST_CUTOFF: assert property (@(posedge aclk) disable iff (!aresetn)
		cyc_strobe && !stn_ok[0] |=> cut_mask[0])
		else $error("Faulty station not cut off.");
	AST_RETURN: assert property (@(posedge aclk) disable iff (!aresetn)
		cyc_strobe && stn_ok[1] && cut_r[1] && !cut_r[0] && c_recon != 4'h0 |=> !cut_mask[1])
		else $error("Recovered station not reconnected.");
	AST_CONT: assert property (@(posedge aclk) disable iff (!aresetn)
		link_ctl && cpu_err && !sys_down && c_cont && !c_sbcfg |=> link_ctl)
		else $error("Link dropped despite continue setting.");
	AST_HANDOVER: assert property (@(posedge aclk) disable iff (!aresetn)
		link_ctl && cpu_err && c_sbcfg |=> !link_ctl)
		else $error("Control kept although a standby is configured.");
	AST_HOLD_RWR: assert property (@(posedge aclk) disable iff (!aresetn)
		cyc_strobe && cut_nxt[0] |=> $stable(rwr_r[0]))
		else $error("Faulty station read register changed.");
	AST_RX_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
		cyc_strobe && cut_nxt[0] && c_fclr && !errinv_r[0] |=> rx_r[BW-1:0] == '0)
		else $error("Faulty station input bits not cleared.");
	AST_ERRINV: assert property (@(posedge aclk) disable iff (!aresetn)
		cyc_strobe && cut_nxt[1] && errinv_r[1] |=> $stable(rx_r[BW +: BW]))
		else $error("Error-invalid station input bits changed.");
	AST_YCLR: assert property (@(posedge aclk) disable iff (!aresetn)
		cpu_stop && c_ydev |=> remote_output_bits == '0)
		else $error("Output bits not cleared at host stop.");
	AST_REFRESH: assert property (@(posedge aclk) disable iff (!aresetn)
		cpu_stop && !c_ydev && !c_stopclr |=> remote_output_bits == $past(ry_r[NSTN*BW-1:0]))
		else $error("Output bits not refreshed at host stop.");
	AST_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
		force_req && cpu_stop && c_stopclr && !wr_ry |=> force_refused && $stable(ry_r))
		else $error("Forced output accepted while stopped.");
	AST_TAKEOVER: assert property (@(posedge aclk) disable iff (!aresetn)
		state_r == fmr_pkg::ST_STBY && ctl_fail && !sys_down && !cpu_err
		|=> link_ctl && stn_no == fmr_pkg::CTL_STNO)
		else $error("Standby did not take control with station zero.");
	AST_REJOIN: assert property (@(posedge aclk) disable iff (!aresetn)
		state_r == fmr_pkg::ST_OFF && !sys_down && !cpu_err && c_duplex
		|=> state_r == fmr_pkg::ST_STBY && stn_no == $past(sbno_r))
		else $error("Former master did not rejoin as standby.");
endmodule
`default_nettype wire

// ---- bench/fmr_net_model.sv ----
// Behavioural model of the slave stations that share the field network.
`timescale 1ns/10ps
`default_nettype none
module fmr_net_model #(
	parameter int NSTN = 4,
	parameter int BW = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [NSTN-1:0] ok_set,
	output logic cyc_strobe,
	output logic [NSTN*BW-1:0] rx_in,
	output logic [NSTN*16-1:0] rwr_in,
	output logic [NSTN-1:0] stn_ok
);
	logic [7:0] scan_r;
	////////////////////////////////////////////////////////////////////////////////
	// One scan every eight cycles; healthy stations send fresh data on each scan.
	// A faulty station's lines change every cycle, so a held value never passes for traffic.
	always_ff @(posedge aclk) begin
		scan_r <= aresetn ? scan_r + 8'h01 : 8'h00;
		cyc_strobe <= aresetn && (scan_r[2:0] == 3'h7);
		stn_ok <= ok_set;
		for (int i = 0; i < NSTN; i++) begin
			rx_in[i*BW+:BW] <= ok_set[i] ? BW'({scan_r[7:3], 3'(i)}) : BW'(~scan_r);
			rwr_in[i*16+:16] <= ok_set[i] ? {8'hC0 | 8'(i), scan_r} : {8'hEE, ~scan_r};
		end
	end
endmodule
`default_nettype wire

// ---- bench/fmr_link_ctl_bench.sv ----
// Self-checking bench for the link reliability block.
`timescale 1ns/10ps
`default_nettype none
module fmr_link_ctl_bench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic host_stop, host_err, host_down, ctl_fail, cyc_strobe, force_req, force_refused;
	logic link_ctl, cyc_active;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rx_in, force_data, remote_output_bits;
	logic [31:0] remote_write_registers, rd;
	logic [3:0] s_axi_wstrb, cut_mask, stn_ok, ok_set;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [6:0] stn_no;
	logic [63:0] rwr_in;
	logic [7:0] lrx [4];
	logic [15:0] lrw [4];
	int num_errors, total_checks;
	////////////////////////////////////////////////////////////////////////////////
	// Block and network model.
	fmr_link_ctl #(.NSTN(4), .BW(8)) i_fmr_link_ctl (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .host_stop, .host_err, .host_down, .ctl_fail, .cyc_strobe, .stn_ok,
		.rx_in, .rwr_in, .force_req, .force_data, .force_refused, .link_ctl, .cyc_active,
		.stn_no, .cut_mask, .remote_output_bits, .remote_write_registers);
	fmr_net_model #(.NSTN(4), .BW(8)) i_fmr_net_model (.aclk, .aresetn, .ok_set,
		.cyc_strobe, .rx_in, .rwr_in, .stn_ok);
	////////////////////////////////////////////////////////////////////////////////
	// Last data each station sent while healthy; that is what a held slot must show.
	always @(posedge aclk) begin
		for (int i = 0; i < 4; i++) begin
			if (cyc_strobe && stn_ok[i]) begin
				lrx[i] <= rx_in[i*8+:8];
				lrw[i] <= rwr_in[i*16+:16];
			end
		end
	end
	// The clock runs at 25 MHz.
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		if (num_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		{host_stop, host_err, host_down, ctl_fail, force_req} <= 5'h00;
		ok_set <= 4'hF;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	// Ready is sampled on the falling edge so the rising edge that follows is the one that takes it.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end while (!(aw && w) && (s_axi_awvalid || s_axi_wvalid));
		do @(negedge aclk); while (!s_axi_bvalid);
		chk("bresp", 32'(er), 32'(s_axi_bresp));
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		axi_rd(a, rd, rs);
		chk("rdata", e & m, rd & m);
		chk("rresp", 32'(fmr_pkg::RESP_OK), 32'(rs));
	endtask
	// Both waits end on a falling edge, where outputs have settled.
	task automatic scans(input int n);
		repeat (n) @(posedge aclk iff cyc_strobe);
		@(negedge aclk);
	endtask
	task automatic edge_n(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_regs();
		rdchk(fmr_pkg::OFS_CTRL, fmr_pkg::RST_CTRL, 32'hFFFF_FFFF);
		rdchk(fmr_pkg::OFS_SBNO, 32'(fmr_pkg::RST_SBNO), 32'h0000_007F);
		axi_wr(fmr_pkg::OFS_STAT, 32'h0000_0000, fmr_pkg::RESP_SLVERR);
		axi_rd(8'hFC, rd, rs);
		chk("unmapped rresp", 32'(fmr_pkg::RESP_SLVERR), 32'(rs));
		chk("idle link", 32'h0, {30'h0, link_ctl, cyc_active});
	endtask
	// Station 1 is error-invalid, station 2 plain faulty, faulty inputs set to clear.
	task automatic t_cut();
		axi_wr(fmr_pkg::OFS_ERRINV, 32'h0000_0002, fmr_pkg::RESP_OK);
		axi_wr(fmr_pkg::OFS_CTRL, 32'h0000_0005, fmr_pkg::RESP_OK);
		scans(2);
		@(posedge aclk);
		ok_set <= 4'h9;
		scans(2);
		chk("cut_mask", 32'h6, 32'(cut_mask));
		chk("link_ctl", 32'h1, 32'(link_ctl));
		rdchk(fmr_pkg::OFS_RXIN, {8'h00, 8'h00, lrx[1], 8'h00}, 32'h00FF_FF00);
		rdchk(fmr_pkg::OFS_RWRIN + 8'h08, 32'(lrw[2]), 32'h0000_FFFF);
		@(posedge aclk);
		ok_set <= 4'hF;
		scans(2);
		chk("no return", 32'h6, 32'(cut_mask));
		axi_wr(fmr_pkg::OFS_CTRL, 32'h0000_0105, fmr_pkg::RESP_OK);
		scans(1);
		chk("one return", 32'h4, 32'(cut_mask));
		scans(1);
		chk("all back", 32'h0, 32'(cut_mask));
	endtask
	// Output area device, other device kept, other device cleared.
	task automatic t_stop();
		logic [31:0] cfg [3] = '{32'h0000_0011, 32'h0000_0001, 32'h0000_0009};
		for (int k = 0; k < 3; k++) begin
			do_reset();
			axi_wr(fmr_pkg::OFS_CTRL, cfg[k], fmr_pkg::RESP_OK);
			axi_wr(fmr_pkg::OFS_RYOUT, 32'hA55A_3CC3, fmr_pkg::RESP_OK);
			@(posedge aclk);
			host_stop <= 1'b1;
			scans(2);
			chk("stop out", (k == 1) ? 32'hA55A_3CC3 : 32'h0, remote_output_bits);
			rdchk(fmr_pkg::OFS_RXIN, {lrx[3], lrx[2], lrx[1], lrx[0]}, 32'hFFFF_FFFF);
			axi_wr(fmr_pkg::OFS_RYOUT, 32'h1234_5678, fmr_pkg::RESP_OK);
			edge_n(2);
			chk("block write", (k == 1) ? 32'h1234_5678 : 32'h0, remote_output_bits);
			@(posedge aclk);
			force_req <= 1'b1;
			@(posedge aclk);
			force_req <= 1'b0;
			@(negedge aclk);
			chk("force refused", 32'(k == 2), 32'(force_refused));
		end
	endtask
	// Each role scenario starts from a fresh reset so no earlier state carries over.
	task automatic t_role();
		do_reset();
		axi_wr(fmr_pkg::OFS_CTRL, 32'h0000_0021, fmr_pkg::RESP_OK);
		@(posedge aclk);
		host_err <= 1'b1;
		edge_n(6);
		chk("continue", 32'h3, {30'h0, link_ctl, cyc_active});
		do_reset();
		axi_wr(fmr_pkg::OFS_CTRL, 32'h0000_0061, fmr_pkg::RESP_OK);
		@(posedge aclk);
		host_err <= 1'b1;
		edge_n(6);
		chk("standby overrides", 32'h0, 32'(link_ctl));
		do_reset();
		axi_wr(fmr_pkg::OFS_SBNO, 32'h0000_0023, fmr_pkg::RESP_OK);
		axi_wr(fmr_pkg::OFS_CTRL, 32'h0000_00C1, fmr_pkg::RESP_OK);
		edge_n(2);
		chk("master", 32'h1, 32'(link_ctl));
		@(posedge aclk);
		host_down <= 1'b1;
		edge_n(6);
		chk("down", 32'h0, 32'(link_ctl));
		@(posedge aclk);
		host_down <= 1'b0;
		edge_n(6);
		chk("rejoin", 32'h1, {30'h0, link_ctl, cyc_active});
		chk("rejoin number", 32'h23, 32'(stn_no));
	endtask
	// The host saves the received input bits and writes them back as outputs once this station takes over.
	task automatic t_fail();
		do_reset();
		axi_wr(fmr_pkg::OFS_SBNO, 32'h0000_0005, fmr_pkg::RESP_OK);
		axi_wr(fmr_pkg::OFS_CTRL, 32'h0000_0007, fmr_pkg::RESP_OK);
		scans(2);
		axi_rd(fmr_pkg::OFS_RXIN, rd, rs);
		@(posedge aclk);
		ctl_fail <= 1'b1;
		ok_set <= 4'hE;
		edge_n(6);
		chk("takeover", 32'h1, 32'(link_ctl));
		chk("number zero", 32'(fmr_pkg::CTL_STNO), 32'(stn_no));
		axi_wr(fmr_pkg::OFS_RYOUT, rd, fmr_pkg::RESP_OK);
		axi_wr(fmr_pkg::OFS_RWWOUT, 32'hBEEF_0042, fmr_pkg::RESP_OK);
		edge_n(2);
		chk("sent bits", rd, remote_output_bits);
		chk("sent regs", 32'hBEEF_0042, remote_write_registers);
		scans(2);
		rdchk(fmr_pkg::OFS_RXIN, 32'h0000_0000, 32'h0000_00FF);
		// Station 0 comes back, then fails again with faulty inputs set to hold.
		@(posedge aclk);
		ok_set <= 4'hF;
		axi_wr(fmr_pkg::OFS_CTRL, 32'h0000_0103, fmr_pkg::RESP_OK);
		scans(2);
		@(posedge aclk);
		ok_set <= 4'hE;
		scans(2);
		rdchk(fmr_pkg::OFS_RXIN, {24'h0, lrx[0]}, 32'h0000_00FF);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence; every input holds a value from time zero.
	initial begin
		{aresetn, host_stop, host_err, host_down, ctl_fail, force_req} = 6'h00;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		ok_set = 4'hF;
		force_data = 32'h0F0F_0F0F;
		num_errors = 0;
		total_checks = 0;
		do_reset();
		t_regs();
		t_cut();
		t_stop();
		t_role();
		t_fail();
		give_verdict();
	end
	// The run needs a few hundred cycles; a hang is cut off well beyond that.
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
